/* File: gpio_pkg.sv */
// Constants shared by the two-port GPIO block: register map, masks, resets.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package gpio_pkg;

    // ****************************************************************
    // Register byte addresses.
    // ****************************************************************
    localparam logic [7:0] port_a_pin_data_addr = 8'h00;
    localparam logic [7:0] port_a_direction_addr = 8'h04;
    localparam logic [7:0] port_a_pullup_enable_addr = 8'h08;
    localparam logic [7:0] port_a_analog_select_addr = 8'h0C;
    localparam logic [7:0] port_b_pin_data_addr = 8'h10;
    localparam logic [7:0] port_b_direction_addr = 8'h14;
    localparam logic [7:0] port_b_pullup_addr = 8'h18;
    localparam logic [7:0] port_b_analog_select_addr = 8'h1C;
    localparam logic [7:0] port_b_change_irq_addr = 8'h20;
    localparam logic [7:0] option_addr = 8'h24;

    // ****************************************************************
    // Implemented-bit masks.
    // ****************************************************************
    localparam logic [7:0] port_a_data_mask = 8'hEF;
    localparam logic [7:0] port_a_dir_mask = 8'hEF;
    localparam logic [7:0] port_a_dir_fixed = 8'h20;
    localparam logic [7:0] port_a_pullup_mask = 8'h2F;
    localparam logic [7:0] port_a_analog_mask = 8'h0F;
    localparam logic [7:0] port_b_small_mask = 8'h03;
    localparam logic [7:0] port_b_large_mask = 8'hF3;
    localparam logic [7:0] port_b_pullup_small = 8'h02;
    localparam logic [7:0] port_b_pullup_large = 8'hF2;
    localparam logic [7:0] port_b_analog_mask = 8'h02;

    // ****************************************************************
    // Values after reset.
    // ****************************************************************
    localparam logic [7:0] dir_reset = 8'hFF;
    localparam logic [7:0] pullup_reset = 8'hFF;
    localparam logic [7:0] analog_reset = 8'hFF;
    localparam logic [7:0] latch_reset = 8'h00;
    localparam logic [7:0] change_irq_reset = 8'h00;
    localparam logic global_pullup_off = 1'b1;
    localparam int global_pullup_bit = 7;

endpackage : gpio_pkg

/* File: gpio_port_dir_pullup_analog.sv */
// Two byte-wide GPIO ports with direction, latch, pull-up and analog select.
// Assumes an APB master on i_clk and pin inputs synchronous to i_clk.
//
// Summary of operation
// - Direction one disables the driver; zero enables it.
// - Port A direction bit 5 always reads one and ignores writes.
// - Unimplemented bits ignore writes and read as zero.
// - Pull-up needs global enable, input mode, pull-up bit, digital mode.
// - Pin A5 pull-up also on when assigned to master clear.
// - Analog bit one kills digital input, pull-up and change enable.
// - Digital read of an analog pin returns zero.
// - Analog select leaves the digital output path working.
// - Data read returns pin levels; write loads latch from read value.
// - Without a peripheral, output drives only while direction is zero; read shows pin.
// - Small package has port B pins 0 and 1; large adds 7-4.
// - An enabled shared peripheral takes over its pin.
// - Each port B pin has a change enable, cleared at reset.
// - Pull-up is off whenever the direction bit is zero.
// - Global pull-up control resets to the disabled state.
// - Analog select bits reset to analog mode.
// - Pin A7 is open-drain: pulls low or releases only.
// - Highest-priority enabled function controls the pin.
`timescale 1ns/100ps
`default_nettype none

module gpio_port_dir_pullup_analog #(
    parameter bit LARGE_PACKAGE = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [7:0] i_port_a_pin,
    input wire logic [7:0] i_port_b_pin,
    input wire logic i_master_clear_function,
    input wire logic [7:0] i_port_a_periph_en,
    input wire logic [7:0] i_port_a_periph_out,
    input wire logic [7:0] i_port_a_periph_oe_n,
    input wire logic [7:0] i_port_b_periph_en,
    input wire logic [7:0] i_port_b_periph_out,
    input wire logic [7:0] i_port_b_periph_oe_n,
    output logic [7:0] o_port_a_out,
    output logic [7:0] o_port_a_oe_n,
    output logic [7:0] o_port_a_pullup,
    output logic [7:0] o_port_b_out,
    output logic [7:0] o_port_b_oe_n,
    output logic [7:0] o_port_b_pullup,
    output logic [7:0] o_port_a_digital_in,
    output logic [7:0] o_port_b_digital_in,
    output logic [7:0] o_port_b_change_en
);

    // ****************************************************************
    // Masks and bus decode.
    // ****************************************************************
    localparam logic [7:0] b_mask = LARGE_PACKAGE ?
        gpio_pkg::port_b_large_mask : gpio_pkg::port_b_small_mask;
    localparam logic [7:0] b_pu_mask = LARGE_PACKAGE ?
        gpio_pkg::port_b_pullup_large : gpio_pkg::port_b_pullup_small;
    // Pins 0 of port B and 7 of port A never drive high.
    localparam logic [7:0] a_open_drain = 8'h80;
    localparam logic [7:0] b_open_drain = 8'h01;

    logic [7:0] a_latch_r;
    logic [7:0] a_dir_r;
    logic [7:0] a_pu_r;
    logic [7:0] a_ana_r;
    logic [7:0] b_latch_r;
    logic [7:0] b_dir_r;
    logic [7:0] b_pu_r;
    logic [7:0] b_ana_r;
    logic [7:0] b_ioc_r;
    logic global_pullup_r;
    logic [7:0] a_sync1_r;
    logic [7:0] a_sync2_r;
    logic [7:0] b_sync1_r;
    logic [7:0] b_sync2_r;
    logic [7:0] a_read;
    logic [7:0] b_read;
    logic wr;
    logic [31:0] rdata_nxt;
    logic hit;

    assign wr = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;

    // ****************************************************************
    // Pin input synchroniser and digital read path.
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            a_sync1_r <= 8'h00;
            a_sync2_r <= 8'h00;
            b_sync1_r <= 8'h00;
            b_sync2_r <= 8'h00;
        end else begin
            a_sync1_r <= i_port_a_pin;
            a_sync2_r <= a_sync1_r;
            b_sync1_r <= i_port_b_pin;
            b_sync2_r <= b_sync1_r;
        end
    end

    // Analog pins read zero; unimplemented bits read zero.
    assign a_read = a_sync2_r & ~a_ana_r & gpio_pkg::port_a_data_mask;
    assign b_read = b_sync2_r & ~b_ana_r & b_mask;
    assign o_port_a_digital_in = a_read;
    assign o_port_b_digital_in = b_read;
    assign o_port_b_change_en = b_ioc_r & ~b_ana_r;

    // ****************************************************************
    // Register writes.
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            a_latch_r <= gpio_pkg::latch_reset;
            b_latch_r <= gpio_pkg::latch_reset;
        end else if (wr) begin
            // The latch takes written bits; the read-modify-write base is
            // the pin read value supplied by software in i_pwdata.
            if (i_paddr == gpio_pkg::port_a_pin_data_addr) begin
                a_latch_r <= i_pwdata[7:0] & gpio_pkg::port_a_data_mask;
            end
            if (i_paddr == gpio_pkg::port_b_pin_data_addr) begin
                b_latch_r <= i_pwdata[7:0] & b_mask;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            a_dir_r <= gpio_pkg::dir_reset & gpio_pkg::port_a_dir_mask;
            b_dir_r <= gpio_pkg::dir_reset & b_mask;
        end else if (wr) begin
            if (i_paddr == gpio_pkg::port_a_direction_addr) begin
                a_dir_r <= (i_pwdata[7:0] & gpio_pkg::port_a_dir_mask)
                    | gpio_pkg::port_a_dir_fixed;
            end
            if (i_paddr == gpio_pkg::port_b_direction_addr) begin
                b_dir_r <= i_pwdata[7:0] & b_mask;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            a_pu_r <= gpio_pkg::pullup_reset & gpio_pkg::port_a_pullup_mask;
            b_pu_r <= gpio_pkg::pullup_reset & b_pu_mask;
        end else if (wr) begin
            if (i_paddr == gpio_pkg::port_a_pullup_enable_addr) begin
                a_pu_r <= i_pwdata[7:0] & gpio_pkg::port_a_pullup_mask;
            end
            if (i_paddr == gpio_pkg::port_b_pullup_addr) begin
                b_pu_r <= i_pwdata[7:0] & b_pu_mask;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            a_ana_r <= gpio_pkg::analog_reset & gpio_pkg::port_a_analog_mask;
            b_ana_r <= gpio_pkg::analog_reset & gpio_pkg::port_b_analog_mask;
        end else if (wr) begin
            if (i_paddr == gpio_pkg::port_a_analog_select_addr) begin
                a_ana_r <= i_pwdata[7:0] & gpio_pkg::port_a_analog_mask;
            end
            if (i_paddr == gpio_pkg::port_b_analog_select_addr) begin
                b_ana_r <= i_pwdata[7:0] & gpio_pkg::port_b_analog_mask;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            b_ioc_r <= gpio_pkg::change_irq_reset;
            global_pullup_r <= gpio_pkg::global_pullup_off;
        end else if (wr) begin
            if (i_paddr == gpio_pkg::port_b_change_irq_addr) begin
                b_ioc_r <= i_pwdata[7:0] & b_mask;
            end
            if (i_paddr == gpio_pkg::option_addr) begin
                global_pullup_r <= i_pwdata[gpio_pkg::global_pullup_bit];
            end
        end
    end

    // ****************************************************************
    // Register reads.
    // ****************************************************************
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        hit = 1'b1;
        unique case (i_paddr)
            gpio_pkg::port_a_pin_data_addr: rdata_nxt[7:0] = a_read;
            gpio_pkg::port_a_direction_addr: rdata_nxt[7:0] = a_dir_r;
            gpio_pkg::port_a_pullup_enable_addr: rdata_nxt[7:0] = a_pu_r;
            gpio_pkg::port_a_analog_select_addr: rdata_nxt[7:0] = a_ana_r;
            gpio_pkg::port_b_pin_data_addr: rdata_nxt[7:0] = b_read;
            gpio_pkg::port_b_direction_addr: rdata_nxt[7:0] = b_dir_r;
            gpio_pkg::port_b_pullup_addr: rdata_nxt[7:0] = b_pu_r;
            gpio_pkg::port_b_analog_select_addr: rdata_nxt[7:0] = b_ana_r;
            gpio_pkg::port_b_change_irq_addr: rdata_nxt[7:0] = b_ioc_r;
            gpio_pkg::option_addr:
                rdata_nxt[gpio_pkg::global_pullup_bit] = global_pullup_r;
            default: hit = 1'b0;
        endcase
    end

    // Unmapped addresses read zero.
    assign o_prdata = hit ? rdata_nxt : 32'h0000_0000;

    // ****************************************************************
    // Pin drivers and pull-ups.
    // ****************************************************************
    function automatic logic [7:0] drive_oe_n(input logic [7:0] dir,
                                              input logic [7:0] en,
                                              input logic [7:0] p_oe_n,
                                              input logic [7:0] dat,
                                              input logic [7:0] p_out,
                                              input logic [7:0] od);
        logic [7:0] oe_n;
        logic [7:0] val;
        oe_n = (en & p_oe_n) | (~en & dir);
        val = (en & p_out) | (~en & dat);
        drive_oe_n = oe_n | (od & val);
    endfunction : drive_oe_n

    function automatic logic [7:0] pullup_on(input logic [7:0] dir,
                                             input logic [7:0] pu,
                                             input logic [7:0] ana,
                                             input logic gpu_n);
        pullup_on = {8{~gpu_n}} & dir & pu & ~ana;
    endfunction : pullup_on

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_port_a_oe_n <= 8'hFF;
            o_port_b_oe_n <= 8'hFF;
            o_port_a_out <= 8'h00;
            o_port_b_out <= 8'h00;
        end else begin
            // Analog select plays no part here.
            o_port_a_oe_n <= drive_oe_n(a_dir_r, i_port_a_periph_en,
                i_port_a_periph_oe_n, a_latch_r, i_port_a_periph_out,
                a_open_drain) | ~gpio_pkg::port_a_dir_mask;
            o_port_b_oe_n <= drive_oe_n(b_dir_r, i_port_b_periph_en,
                i_port_b_periph_oe_n, b_latch_r, i_port_b_periph_out,
                b_open_drain) | ~b_mask;
            o_port_a_out <= ((i_port_a_periph_en & i_port_a_periph_out)
                | (~i_port_a_periph_en & a_latch_r)) & ~a_open_drain;
            o_port_b_out <= ((i_port_b_periph_en & i_port_b_periph_out)
                | (~i_port_b_periph_en & b_latch_r)) & ~b_open_drain;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_port_a_pullup <= 8'h00;
            o_port_b_pullup <= 8'h00;
        end else begin
            o_port_a_pullup <= pullup_on(a_dir_r, a_pu_r, a_ana_r,
                global_pullup_r) | {2'b00, i_master_clear_function, 5'b00000};
            o_port_b_pullup <= pullup_on(b_dir_r, b_pu_r, b_ana_r,
                global_pullup_r);
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    property p_dir5;
        @(posedge i_clk) disable iff (i_rst) a_dir_r[5] == 1'b1;
    endproperty
    a_dir5: assert property (p_dir5) else $error("dir bit 5 cleared");

    property p_unimpl;
        @(posedge i_clk) disable iff (i_rst)
            (a_dir_r[4] | a_pu_r[4] | (|a_ana_r[7:4])) == 1'b0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimpl bit set");

    property p_drv;
        @(posedge i_clk) disable iff (i_rst)
            (i_port_a_periph_en[3:0] == 4'h0) |=>
            (o_port_a_oe_n[3:0] == $past(a_dir_r[3:0]));
    endproperty
    a_drv: assert property (p_drv) else $error("driver not dir");

    property p_pu;
        @(posedge i_clk) disable iff (i_rst)
            (!i_master_clear_function) |=> (o_port_a_pullup ==
            ($past(a_dir_r & a_pu_r & ~a_ana_r) & {8{!$past(global_pullup_r)}}));
    endproperty
    a_pu: assert property (p_pu) else $error("pull-up wrong");

    property p_master_clear_function;
        @(posedge i_clk) disable iff (i_rst)
            i_master_clear_function |=> o_port_a_pullup[5];
    endproperty
    a_master_clear_function: assert property (p_master_clear_function) else $error("A5 pull-up off");

    property p_anaread;
        @(posedge i_clk) disable iff (i_rst) (a_read & a_ana_r) == 8'h00;
    endproperty
    a_anaread: assert property (p_anaread) else $error("analog read 1");

    property p_od;
        @(posedge i_clk) disable iff (i_rst)
            !o_port_a_out[7] && !o_port_b_out[0];
    endproperty
    a_od: assert property (p_od) else $error("open drain high");

    property p_ioc_rst;
        @(posedge i_clk) $fell(i_rst) |-> o_port_b_change_en == 8'h00;
    endproperty
    a_ioc_rst: assert property (p_ioc_rst) else $error("ioc set");

    property p_sync;
        @(posedge i_clk) disable iff (i_rst)
            (!$past(i_rst) && !$past(i_rst, 2)) |->
            a_sync2_r == $past(i_port_a_pin, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync delay");

    property p_pu_out;
        @(posedge i_clk) disable iff (i_rst)
            ((o_port_a_pullup & ~$past(a_dir_r)) |
            (o_port_b_pullup & ~$past(b_dir_r))) == 8'h00;
    endproperty
    a_pu_out: assert property (p_pu_out) else $error("pu on out");

    property p_ana_pu;
        @(posedge i_clk) disable iff (i_rst)
            ((o_port_a_pullup & $past(a_ana_r)) |
            (o_port_b_pullup & $past(b_ana_r))) == 8'h00;
    endproperty
    a_ana_pu: assert property (p_ana_pu) else $error("pu ana");

    property p_ana_out;
        @(posedge i_clk) disable iff (i_rst)
            (i_port_a_periph_en[3:0] == 4'h0) |=>
            (o_port_a_out[3:0] == $past(a_latch_r[3:0]));
    endproperty
    a_ana_out: assert property (p_ana_out) else $error("no out");

    property p_no_drv;
        @(posedge i_clk) disable iff (i_rst)
            ((~o_port_a_oe_n & ~gpio_pkg::port_a_dir_mask) |
            (~o_port_b_oe_n & ~b_mask)) == 8'h00;
    endproperty
    a_no_drv: assert property (p_no_drv) else $error("pin drv");

    property p_take;
        @(posedge i_clk) disable iff (i_rst)
            (i_port_b_periph_en[1] && !i_port_b_periph_oe_n[1]) |=>
            (!o_port_b_oe_n[1] &&
            o_port_b_out[1] == $past(i_port_b_periph_out[1]));
    endproperty
    a_take: assert property (p_take) else $error("no takeover");

    property p_global;
        @(posedge i_clk) disable iff (i_rst)
            global_pullup_r |=>
            ((o_port_a_pullup & 8'hDF) | o_port_b_pullup) == 8'h00;
    endproperty
    a_global: assert property (p_global) else $error("pu on");

endmodule : gpio_port_dir_pullup_analog

`default_nettype wire

/* File: gpio_pin_model.sv */
// Board-side model of one byte-wide port that resolves each pin level.
// Assumes the block drives a pin while its enable is low.
`timescale 1ns/100ps
`default_nettype none

module gpio_pin_model (
    input wire logic i_clk,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe_n,
    input wire logic [7:0] i_pullup,
    input wire logic [7:0] i_ext_en,
    input wire logic [7:0] i_ext_val,
    output logic [7:0] o_pin
);
    logic [7:0] float_r = 8'h5A;

    // A floating pin wanders every cycle so that no stale level is read.
    always_ff @(posedge i_clk) begin
        float_r <= ~float_r;
    end

    always_comb begin
        o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext_en & i_ext_val)
            | (i_oe_n & ~i_ext_en & (i_pullup | float_r));
    end
endmodule : gpio_pin_model
`default_nettype wire

/* File: gpio_port_dir_pullup_analog_tb_top.sv */
// Self-checking random bench for the two-port GPIO block.
// Assumes the design package and the pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module gpio_port_dir_pullup_analog_tb_top;
    logic i_clk, i_rst, psel, pen, pwr, prdy, perr, master_clear_function;
    logic [7:0] padr, a_pin, b_pin, a_en, a_po, a_poe, b_en, b_po, b_poe;
    logic [7:0] a_xe, a_xv, b_xe, b_xv, a_out, a_oe, a_pu, b_out, b_oe;
    logic [7:0] b_pu, a_din, b_din, b_chg;
    logic [7:0] ta[11], tm[8], tr[8], wv[11];
    logic [31:0] pwd, prd, rd, seed;
    int errors, n_compared;

    gpio_port_dir_pullup_analog dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
        .i_port_a_pin(a_pin), .i_port_b_pin(b_pin),
        .i_master_clear_function(master_clear_function), .i_port_a_periph_en(a_en),
        .i_port_a_periph_out(a_po), .i_port_a_periph_oe_n(a_poe),
        .i_port_b_periph_en(b_en), .i_port_b_periph_out(b_po),
        .i_port_b_periph_oe_n(b_poe), .o_port_a_out(a_out),
        .o_port_a_oe_n(a_oe), .o_port_a_pullup(a_pu), .o_port_b_out(b_out),
        .o_port_b_oe_n(b_oe), .o_port_b_pullup(b_pu),
        .o_port_a_digital_in(a_din), .o_port_b_digital_in(b_din),
        .o_port_b_change_en(b_chg));
    gpio_pin_model pa (.i_clk(i_clk), .i_out(a_out), .i_oe_n(a_oe),
        .i_pullup(a_pu), .i_ext_en(a_xe), .i_ext_val(a_xv), .o_pin(a_pin));
    gpio_pin_model pb (.i_clk(i_clk), .i_out(b_out), .i_oe_n(b_oe),
        .i_pullup(b_pu), .i_ext_en(b_xe), .i_ext_val(b_xv), .o_pin(b_pin));

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic stop_test();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] e, g, m);
        n_compared++;
        if (((e ^ g) & m) !== 32'h0) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e & m, g & m);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= {24'h000000, d};
        @(posedge i_clk);
        pen <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (prdy !== 1'b1);
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    // Works out pin, pull-up and read values of one port and compares.
    task automatic pchk(input logic [7:0] lat, dir, pu, an, en, po, poe, xe,
        xv, od, imp, dm, ad, input logic gn, mc,
        input logic [7:0] go, ge, gp, gd);
        logic [7:0] v, d, o, e, p, pin, kn;
        v = (en & po) | (~en & lat);
        d = (en & poe) | (~en & dir);
        o = v & ~od & imp;
        e = ~imp | d | (od & v);
        p = (gn ? 8'h00 : dir & pu & ~an) | {2'b00, mc, 5'b00000};
        pin = (~e & o) | (e & xe & xv) | (e & ~xe & p);
        kn = ~e | xe | p | ~dm;
        chk(o, go, imp);
        chk(e, ge, 8'hFF);
        chk(p, gp, ~en);
        chk(pin & dm & ~an, gd, kn);
        apb(1'b0, ad, 8'h00);
        chk(pin & dm & ~an, rd, {24'hFFFFFF, kn});
    endtask : pchk

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        stop_test();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        int it, i;
        {psel, pen, pwr, master_clear_function, padr, pwd} = '0;
        {a_en, a_po, a_poe, b_en, b_po, b_poe} = '0;
        {a_xe, a_xv, b_xe, b_xv} = '0;
        errors = 0;
        n_compared = 0;
        seed = 32'd99;
        ta = '{gpio_pkg::port_a_direction_addr,
            gpio_pkg::port_a_pullup_enable_addr,
            gpio_pkg::port_a_analog_select_addr,
            gpio_pkg::port_b_direction_addr, gpio_pkg::port_b_pullup_addr,
            gpio_pkg::port_b_analog_select_addr,
            gpio_pkg::port_b_change_irq_addr, 8'h30,
            gpio_pkg::port_a_pin_data_addr, gpio_pkg::port_b_pin_data_addr,
            gpio_pkg::option_addr};
        tm = '{8'hEF, 8'h2F, 8'h0F, 8'h03, 8'h02, 8'h02, 8'h03, 8'h00};
        tr = '{8'hEF, 8'h2F, 8'h0F, 8'h03, 8'h02, 8'h02, 8'h00, 8'h00};
        i_rst = 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        chk(32'hFF, a_oe, 32'hFF);
        chk(32'h00, a_pu | b_pu, 32'hFF);
        apb(1'b0, gpio_pkg::option_addr, 8'h00);
        chk(32'h80, rd, 32'h80);
        for (i = 0; i < 8; i++) begin
            apb(1'b0, ta[i], 8'h00);
            chk({24'h0, tr[i]}, rd, 32'hFFFFFFFF);
            chk(32'h1, {30'h0, perr, prdy}, 32'h3);
            wv[0] = 8'(rnd());
            apb(1'b1, ta[i], wv[0]);
            apb(1'b0, ta[i], 8'h00);
            chk({24'h0, (wv[0] & tm[i]) | (i == 0 ? 8'h20 : 8'h00)}, rd,
                32'hFFFFFFFF);
        end
        for (it = 0; it < 40; it++) begin
            for (i = 0; i < 11; i++) begin
                wv[i] = 8'(rnd());
            end
            if (it == 0) begin
                wv[0] = 8'hFF;
                wv[1] = 8'hFF;
                wv[2] = 8'h00;
                wv[10] = 8'h00;
            end
            if (it[1]) begin
                wv[0] = wv[0] | wv[2];
                wv[3] = wv[3] | wv[5];
            end
            for (i = 0; i < 11; i++) begin
                apb(1'b1, ta[i], wv[i]);
            end
            a_en <= 8'(rnd()) & (it[0] ? 8'hCF : 8'h00);
            b_en <= 8'(rnd()) & (it[0] ? 8'h03 : 8'h00);
            {a_po, a_poe, b_po, b_poe} <= rnd();
            {a_xe, a_xv, b_xe, b_xv} <= rnd();
            master_clear_function <= 1'(rnd());
            repeat (4) @(posedge i_clk);
            pchk(wv[8], (wv[0] & 8'hEF) | 8'h20, wv[1] & 8'h2F,
                wv[2] & 8'h0F, a_en, a_po, a_poe, a_xe, a_xv, 8'h80,
                8'hCF, 8'hEF, ta[8], wv[10][7], master_clear_function, a_out, a_oe, a_pu,
                a_din);
            pchk(wv[9], wv[3] & 8'h03, wv[4] & 8'h02, wv[5] & 8'h02,
                b_en, b_po, b_poe, b_xe, b_xv, 8'h01, 8'h03, 8'h03, ta[9],
                wv[10][7], 1'b0, b_out, b_oe, b_pu, b_din);
            chk(wv[6] & 8'h03 & ~(wv[5] & 8'h02), b_chg, 8'hFF);
        end
        stop_test();
    end
endmodule : gpio_port_dir_pullup_analog_tb_top
`default_nettype wire
